// file: core/ew_pkg.sv
package ew_pkg;

    localparam int ADDR_W_BYTE     = 11;
    localparam int ADDR_W_WORD     = 10;
    localparam int DATA_W_BYTE     = 8;
    localparam int DATA_W_WORD     = 16;
    localparam int SHIFT_W         = 28;
    localparam int CNT_W           = 5;
    localparam int MEM_BYTES       = 2048;
    localparam int CLK_PERIOD_NS   = 25;
    localparam int T_CSL_NS        = 250;
    localparam int CSL_CYCLES      =
        (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEF_PROG_CYCLES = 200;

    localparam logic [1:0]  OP_READ     = 2'h2;
    localparam logic [1:0]  OP_WRITE    = 2'h1;
    localparam logic [1:0]  OP_ERASE    = 2'h3;
    localparam logic [1:0]  OP_EXT      = 2'h0;
    localparam logic [1:0]  EXT_ERASE_ALL_CMD    = 2'h2;
    localparam logic [1:0]  EXT_LOCK    = 2'h0;
    localparam logic [1:0]  EXT_UNLOCK  = 2'h3;
    localparam logic [1:0]  EXT_WRITE_ALL_CMD    = 2'h1;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    typedef enum logic [2:0] {
        CMD_ERASE  = 3'h0,
        CMD_ERASE_ALL_CMD   = 3'h1,
        CMD_LOCK   = 3'h2,
        CMD_UNLOCK = 3'h3,
        CMD_WRITE  = 3'h4,
        CMD_WRITE_ALL_CMD   = 3'h5
    } ew_cmd_t;

    typedef enum logic [1:0] {
        PG_IDLE = 2'h0,
        PG_PEND = 2'h1,
        PG_BUSY = 2'h2
    } ew_prog_t;

endpackage

// file: core/ew_mem_if.sv
interface ew_mem_if;
    logic        we;
    logic        fill;
    logic        wide;
    logic [10:0] waddr;
    logic [15:0] wdata;
    logic        rwide;
    logic [10:0] raddr;
    logic [15:0] rdata;

    modport ctl (
        output we, fill, wide, waddr, wdata, rwide, raddr,
        input  rdata
    );
    modport mem (
        input  we, fill, wide, waddr, wdata, rwide, raddr,
        output rdata
    );
endinterface

// file: core/ew_cell_array.sv
module ew_cell_array #(
    parameter int DEPTH = ew_pkg::MEM_BYTES
) (
    input  wire logic  clk,
    ew_mem_if.mem      m
);
    logic [7:0] cells [DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // programming port
    always_ff @(posedge clk) begin
        if (m.we) begin
            if (m.fill) begin
                for (int i = 0; i < DEPTH; i++) begin
                    cells[i] <= (m.wide && !i[0]) ? m.wdata[15:8]
                                                  : m.wdata[7:0];
                end
            end else if (m.wide) begin
                cells[{m.waddr[9:0], 1'b0}] <= m.wdata[15:8];
                cells[{m.waddr[9:0], 1'b1}] <= m.wdata[7:0];
            end else begin
                cells[m.waddr] <= m.wdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, msb aligned
    assign m.rdata = m.rwide ? {cells[{m.raddr[9:0], 1'b0}],
                                cells[{m.raddr[9:0], 1'b1}]}
                             : {cells[m.raddr], 8'h00};
endmodule

// file: core/ew_cmd_port.sv
module ew_cmd_port #(
    parameter int PROG_CYCLES = ew_pkg::DEF_PROG_CYCLES,
    parameter bit HV_ONLY     = 1'b0,
    parameter bit HAS_PERMIT  = 1'b0
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic sclk,
    input  wire logic cs,
    input  wire logic serial_in,
    output logic      serial_out,
    output logic      serial_out_oe,
    output logic      ready_busy_flag,
    input  wire logic word_width_select,
    input  wire logic program_permit_pin
);
    localparam int BW = $clog2(PROG_CYCLES + 1);

    ew_mem_if m ();

    ew_cell_array u_cells (
        .clk (clk),
        .m   (m)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock domain inputs
    logic cs_s1, cs_s2, cs_prev;
    logic org_s1, org_s2;
    logic pp_s1, pp_s2;
    logic ct_s1, ct_s2, ct_s3;
    logic st_s1, st_s2, st_s3;
    logic cmd_tgl, st_tgl;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {cs_s1, cs_s2, cs_prev} <= 3'h0;
            {org_s1, org_s2}        <= 2'h0;
            {pp_s1, pp_s2}          <= 2'h0;
            {ct_s1, ct_s2, ct_s3}   <= 3'h0;
            {st_s1, st_s2, st_s3}   <= 3'h0;
        end else begin
            {cs_s1, cs_s2, cs_prev} <= {cs, cs_s1, cs_s2};
            {org_s1, org_s2}        <= {word_width_select, org_s1};
            {pp_s1, pp_s2}          <= {program_permit_pin, pp_s1};
            {ct_s1, ct_s2, ct_s3}   <= {cmd_tgl, ct_s1, ct_s2};
            {st_s1, st_s2, st_s3}   <= {st_tgl, st_s1, st_s2};
        end
    end

    logic cmd_evt, st_evt;
    assign cmd_evt = ct_s2 ^ ct_s3;
    assign st_evt  = st_s2 ^ st_s3;

    ////////////////////////////////////////////////////////////////////////
    // link sequencer, held in reset while select is low
    logic                       link_rst_n;
    logic                       started, done;
    logic [ew_pkg::CNT_W-1:0]   cnt;
    logic [ew_pkg::SHIFT_W-1:0] sh, next_sh;
    logic [1:0]                 op, ext;
    logic                       need_data, addr_last, cmd_last;
    logic [ew_pkg::CNT_W-1:0]   aw, dw;

    assign link_rst_n = arst_n & cs;
    assign next_sh    = {sh[ew_pkg::SHIFT_W-2:0], serial_in};

    always_comb begin
        aw = org_s2 ? ew_pkg::CNT_W'(ew_pkg::ADDR_W_WORD)
                    : ew_pkg::CNT_W'(ew_pkg::ADDR_W_BYTE);
        dw = org_s2 ? ew_pkg::CNT_W'(ew_pkg::DATA_W_WORD)
                    : ew_pkg::CNT_W'(ew_pkg::DATA_W_BYTE);
        need_data = (op == ew_pkg::OP_WRITE)
                 || (op == ew_pkg::OP_EXT && ext == ew_pkg::EXT_WRITE_ALL_CMD);
        addr_last = started && !done && cnt == aw + 5'h01;
        cmd_last  = need_data ? (started && !done
                                 && cnt == aw + dw + 5'h01)
                              : addr_last;
    end

    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            started <= 1'b0;
            done    <= 1'b0;
            cnt     <= '0;
            sh      <= '0;
            op      <= 2'h0;
            ext     <= 2'h0;
        end else if (!started) begin
            if (serial_in) begin
                started <= 1'b1;
            end
        end else if (!done) begin
            sh  <= next_sh;
            cnt <= cnt + 5'h01;
            if (cnt == 5'h01) begin
                op <= next_sh[1:0];
            end
            if (cnt == 5'h03) begin
                ext <= next_sh[1:0];
            end
            if (cmd_last) begin
                done <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read shifter
    logic        rd_active, rd_bit;
    logic [15:0] rd_word;

    assign m.rwide = org_s2;
    assign m.raddr = org_s2 ? {1'b0, next_sh[9:0]} : next_sh[10:0];

    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rd_active <= 1'b0;
            rd_bit    <= 1'b0;
            rd_word   <= 16'h0000;
        end else if (addr_last && op == ew_pkg::OP_READ) begin
            rd_active <= 1'b1;
            rd_bit    <= 1'b0;
            rd_word   <= m.rdata;
        end else if (rd_active) begin
            rd_bit  <= rd_word[15];
            rd_word <= {rd_word[14:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // payload handed to the clock domain, survives select low
    ew_pkg::ew_cmd_t            p_cmd, dec_cmd;
    logic [10:0]                p_addr;
    logic [15:0]                p_data;
    logic                       p_wide;
    logic [ew_pkg::SHIFT_W-1:0] adr_src;

    always_comb begin
        adr_src = need_data ? (next_sh >> dw) : next_sh;
        case (op)
            ew_pkg::OP_WRITE: dec_cmd = ew_pkg::CMD_WRITE;
            ew_pkg::OP_ERASE: dec_cmd = ew_pkg::CMD_ERASE;
            default: begin
                case (ext)
                    ew_pkg::EXT_ERASE_ALL_CMD:   dec_cmd = ew_pkg::CMD_ERASE_ALL_CMD;
                    ew_pkg::EXT_UNLOCK: dec_cmd = ew_pkg::CMD_UNLOCK;
                    ew_pkg::EXT_WRITE_ALL_CMD:   dec_cmd = ew_pkg::CMD_WRITE_ALL_CMD;
                    default:            dec_cmd = ew_pkg::CMD_LOCK;
                endcase
            end
        endcase
    end

    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            p_cmd   <= ew_pkg::CMD_LOCK;
            p_addr  <= 11'h000;
            p_data  <= 16'h0000;
            p_wide  <= 1'b0;
            cmd_tgl <= 1'b0;
        end else if (cs && cmd_last && op != ew_pkg::OP_READ) begin
            p_cmd   <= dec_cmd;
            p_addr  <= org_s2 ? {1'b0, adr_src[9:0]} : adr_src[10:0];
            p_data  <= org_s2 ? next_sh[15:0] : {8'h00, next_sh[7:0]};
            p_wide  <= org_s2;
            cmd_tgl <= ~cmd_tgl;
        end
    end

    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            st_tgl <= 1'b0;
        end else if (cs && !started && serial_in) begin
            st_tgl <= ~st_tgl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // programming sequencer
    ew_pkg::ew_prog_t state;
    ew_pkg::ew_cmd_t  c_cmd;
    logic [10:0]      c_addr;
    logic [15:0]      c_data;
    logic             c_wide;
    logic [BW-1:0]    busy_cnt;
    logic             unlocked, permit_ok, exec, prog_start, is_prog;

    assign permit_ok  = !HAS_PERMIT || pp_s2;
    assign exec       = state == ew_pkg::PG_PEND
                     && (HV_ONLY || !cs_s2);
    assign is_prog    = c_cmd != ew_pkg::CMD_LOCK
                     && c_cmd != ew_pkg::CMD_UNLOCK;
    assign prog_start = exec && is_prog && unlocked && permit_ok;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= ew_pkg::PG_IDLE;
            c_cmd    <= ew_pkg::CMD_LOCK;
            c_addr   <= 11'h000;
            c_data   <= 16'h0000;
            c_wide   <= 1'b0;
            busy_cnt <= '0;
        end else begin
            case (state)
                ew_pkg::PG_IDLE: begin
                    if (cmd_evt) begin
                        c_cmd  <= p_cmd;
                        c_addr <= p_addr;
                        c_data <= p_data;
                        c_wide <= p_wide;
                        state  <= ew_pkg::PG_PEND;
                    end
                end
                ew_pkg::PG_PEND: begin
                    if (prog_start) begin
                        busy_cnt <= BW'(PROG_CYCLES - 1);
                        state    <= ew_pkg::PG_BUSY;
                    end else if (exec) begin
                        state <= ew_pkg::PG_IDLE;
                    end
                end
                ew_pkg::PG_BUSY: begin
                    if (busy_cnt == '0) begin
                        state <= ew_pkg::PG_IDLE;
                    end else begin
                        busy_cnt <= busy_cnt - 1'b1;
                    end
                end
                default: state <= ew_pkg::PG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            unlocked <= 1'b0;
        end else if (exec && c_cmd == ew_pkg::CMD_UNLOCK) begin
            unlocked <= 1'b1;
        end else if (exec && c_cmd == ew_pkg::CMD_LOCK) begin
            unlocked <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            m.we    <= 1'b0;
            m.fill  <= 1'b0;
            m.wide  <= 1'b0;
            m.waddr <= 11'h000;
            m.wdata <= 16'h0000;
        end else begin
            m.we    <= prog_start;
            m.fill  <= c_cmd == ew_pkg::CMD_ERASE_ALL_CMD
                    || c_cmd == ew_pkg::CMD_WRITE_ALL_CMD;
            m.wide  <= c_wide;
            m.waddr <= c_addr;
            m.wdata <= (c_cmd == ew_pkg::CMD_ERASE
                     || c_cmd == ew_pkg::CMD_ERASE_ALL_CMD)
                     ? ew_pkg::ERASED_WORD : c_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ready/busy status on the output
    logic [3:0] csl_cnt;
    logic       armed, status_show;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            csl_cnt <= 4'h0;
        end else if (!cs_s2 && cs_prev) begin
            csl_cnt <= 4'h1;
        end else if (!cs_s2 && csl_cnt != 4'(ew_pkg::CSL_CYCLES)) begin
            csl_cnt <= csl_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed <= 1'b0;
        end else if (prog_start) begin
            armed <= 1'b1;
        end else if (st_evt) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_show <= 1'b0;
        end else if (!cs_s2) begin
            status_show <= 1'b0;
        end else if (!cs_prev) begin
            status_show <= armed
                && csl_cnt == 4'(ew_pkg::CSL_CYCLES);
        end
    end

    assign ready_busy_flag = state != ew_pkg::PG_BUSY;
    assign serial_out      = rd_active ? rd_bit : ready_busy_flag;
    assign serial_out_oe   = cs & (rd_active | status_show);

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [15:0] busy_len;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_len <= 16'h0000;
        end else if (state == ew_pkg::PG_BUSY) begin
            busy_len <= busy_len + 16'h0001;
        end else begin
            busy_len <= 16'h0000;
        end
    end

    a_busy_length: assert property (
        @(posedge clk) disable iff (!arst_n)
        $fell(state == ew_pkg::PG_BUSY) |-> busy_len == 16'(PROG_CYCLES))
        else $error("busy time differs from programming time");

    a_out_release: assert property (
        @(posedge clk) disable iff (!arst_n)
        !cs |-> !serial_out_oe)
        else $error("output driven while select low");

    a_oe_cause: assert property (
        @(posedge clk) disable iff (!arst_n)
        serial_out_oe |-> rd_active || (status_show && cs_s2))
        else $error("output driven without read or status");

    a_status_level: assert property (
        @(posedge clk) disable iff (!arst_n)
        serial_out_oe && !rd_active
        |-> serial_out == (state != ew_pkg::PG_BUSY))
        else $error("status level wrong");

    a_locked_write: assert property (
        @(posedge clk) disable iff (!arst_n)
        m.we |-> $past(unlocked))
        else $error("array written while locked");

    a_permit_write: assert property (
        @(posedge clk) disable iff (!arst_n)
        m.we |-> $past(permit_ok) ##0 state == ew_pkg::PG_BUSY)
        else $error("array written without permit");

    a_erase_ones: assert property (
        @(posedge clk) disable iff (!arst_n)
        m.we && $past(c_cmd) == ew_pkg::CMD_ERASE
        |-> m.wdata == ew_pkg::ERASED_WORD && !m.fill)
        else $error("erase did not write ones");

    a_pend_wait: assert property (
        @(posedge clk) disable iff (!arst_n)
        state == ew_pkg::PG_PEND && cs_s2 && !HV_ONLY
        |=> state == ew_pkg::PG_PEND)
        else $error("cycle began before select fell");

    a_status_clear: assert property (
        @(posedge clk) disable iff (!arst_n)
        st_evt && !prog_start |=> !armed ##1 !armed || $past(prog_start))
        else $error("status not cleared after start bit");

    a_dummy_zero: assert property (
        @(posedge sclk) disable iff (!link_rst_n)
        $rose(rd_active) |-> !serial_out && serial_out_oe)
        else $error("no dummy zero before read data");

    a_quiet_idle: assert property (
        @(posedge sclk) disable iff (!link_rst_n)
        !started |-> !rd_active && !done && cnt == 5'h00)
        else $error("activity before start bit");
endmodule

// file: tb/ew_host.sv
module ew_host (
    output logic      sclk,
    output logic      cs,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk = 1'b0;
        cs = 1'b0;
        serial_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one link bit, data set while clock low
    task automatic pulse(input logic b, output logic s);
        serial_in = b;
        #40 sclk = 1'b1;
        #20 s = serial_out_oe ? serial_out : ~serial_out;
        #20 sclk = 1'b0;
    endtask

    // select raised with clock held low
    task automatic cs_up();
        cs = 1'b1;
        #40;
    endtask

    // select low well past the minimum low time
    task automatic cs_dn();
        cs = 1'b0;
        serial_in = ~serial_in;
        #400;
    endtask

    // select dropped, data line left as it is
    task automatic cs_drop();
        cs = 1'b0;
    endtask

    // whole instruction, msb first, capture of the last nrd+1 outputs
    task automatic frame(input logic [31:0] bits, input int n,
                         input int lead, input int nrd, input int trail,
                         output logic [16:0] rd);
        logic s;
        rd = '0;
        cs_up();
        repeat (lead) pulse(1'b0, s);
        for (int i = 0; i < n; i++) begin
            pulse(bits[n-1-i], s);
            if (i >= n - nrd - 1) rd = {rd[15:0], s};
        end
        repeat (trail) pulse(1'b1, s);
        cs_dn();
    endtask
endmodule

// file: tb/tb_three_wire_eeprom_command_port.sv
module tb_three_wire_eeprom_command_port;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        arst_n;
    logic        sclk;
    logic        cs;
    logic        serial_in;
    logic        serial_out;
    logic        serial_out_oe;
    logic        ready_busy_flag;
    logic        word_width_select;
    logic        program_permit_pin;
    logic [31:0] seed = 32'h17;
    logic [16:0] exp_q[$];
    logic [16:0] obs_q[$];
    string       nm_q[$];
    int          errors = 0;
    int          n_tests = 0;

    ew_cmd_port #(.PROG_CYCLES(60), .HAS_PERMIT(1'b1)) u_dut (
        .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs(cs),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .ready_busy_flag(ready_busy_flag),
        .word_width_select(word_width_select),
        .program_permit_pin(program_permit_pin)
    );

    ew_host u_host (
        .sclk(sclk), .cs(cs), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic note(input string nm, input logic [16:0] e,
                        input logic [16:0] o);
        nm_q.push_back(nm);
        exp_q.push_back(e);
        obs_q.push_back(o);
    endtask

    // oldest note against what was seen
    always @(posedge clk) begin
        while (exp_q.size() > 0) begin
            n_tests++;
            if (obs_q[0] !== exp_q[0]) begin
                errors++;
                $display("unexpected %s: expected %h, seen %h",
                         nm_q[0], exp_q[0], obs_q[0]);
            end
            nm_q.delete(0);
            exp_q.delete(0);
            obs_q.delete(0);
        end
    end

    task automatic close_out();
        $display("checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        errors++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic wide);
        @(negedge clk);
        arst_n = 1'b0;
        word_width_select = wide;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    // command frame, then status check, and poll and clear when busy
    task automatic prog(input logic [31:0] bits, input int n,
                        input int trail, input logic busy);
        logic [16:0] rd;
        logic        s;
        int          k;
        u_host.frame(bits, n, 0, 0, trail, rd);
        u_host.cs_up();
        repeat (6) @(negedge clk);
        note("status_oe", {16'h0, busy}, {16'h0, serial_out_oe});
        note("flag", {16'h0, ~busy}, {16'h0, ready_busy_flag});
        if (busy) begin
            note("status_busy", 17'h0, {16'h0, serial_out});
            k = 0;
            while (ready_busy_flag !== 1'b1 && k < 300) begin
                @(negedge clk);
                k++;
            end
            note("busy_len", 17'h1, {16'h0, k > 30 && k < 50});
            note("status_rdy", 17'h1, {16'h0, serial_out});
            u_host.pulse(1'b1, s);
            cs_low_check();
            u_host.cs_up();
            repeat (6) @(negedge clk);
            note("cleared_oe", 17'h0, {16'h0, serial_out_oe});
        end
        u_host.cs_dn();
    endtask

    task automatic cs_low_check();
        u_host.cs_drop();
        #1 note("fall_oe", 17'h0, {16'h0, serial_out_oe});
        #400;
    endtask

    task automatic rd_chk(input logic [10:0] a, input logic wide,
                          input logic [15:0] d);
        logic [16:0] rd;
        if (wide) begin
            u_host.frame({1'b1, 2'b10, a[9:0], 16'h0}, 29, 3, 16, 2, rd);
            note("read_word", {1'b0, d}, rd);
        end else begin
            u_host.frame({1'b1, 2'b10, a, 8'h0}, 22, 3, 8, 2, rd);
            note("read_byte", {9'h0, d[7:0]}, rd);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [10:0] a;
        logic [7:0]  d1;
        logic [15:0] w;
        logic [16:0] rd;
        arst_n = 1'b0;
        word_width_select = 1'b0;
        program_permit_pin = 1'b1;
        do_reset(1'b0);
        note("idle_oe", 17'h0, {16'h0, serial_out_oe});
        note("idle_flag", 17'h1, {16'h0, ready_busy_flag});
        r = rnd();
        a = r[10:0];
        d1 = r[23:16];
        prog({1'b1, 2'b01, a, d1}, 22, 2, 1'b0);
        u_host.frame({1'b1, 2'b00, 2'b11, 9'h0}, 14, 0, 0, 0, rd);
        prog({1'b1, 2'b00, 2'b10, 9'h0}, 14, 2, 1'b1);
        rd_chk(a, 1'b0, 16'hFF);
        prog({1'b1, 2'b01, a, d1}, 22, 2, 1'b1);
        rd_chk(a, 1'b0, {8'h0, d1});
        prog({1'b1, 2'b01, a, ~d1[7:2]}, 20, 0, 1'b0);
        rd_chk(a, 1'b0, {8'h0, d1});
        @(negedge clk);
        program_permit_pin = 1'b0;
        prog({1'b1, 2'b01, a, ~d1}, 22, 2, 1'b0);
        @(negedge clk);
        program_permit_pin = 1'b1;
        rd_chk(a, 1'b0, {8'h0, d1});
        prog({1'b1, 2'b11, a}, 14, 2, 1'b1);
        rd_chk(a, 1'b0, 16'hFF);
        u_host.frame({1'b1, 2'b00, 2'b00, 9'h0}, 14, 0, 0, 0, rd);
        prog({1'b1, 2'b01, a, d1}, 22, 2, 1'b0);
        rd_chk(a, 1'b0, 16'hFF);
        do_reset(1'b1);
        r = rnd();
        w = r[15:0];
        u_host.frame({1'b1, 2'b00, 2'b11, 8'h0}, 13, 0, 0, 0, rd);
        prog({1'b1, 2'b01, r[25:16], w}, 29, 2, 1'b1);
        rd_chk({1'b0, r[25:16]}, 1'b1, w);
        prog({1'b1, 2'b00, 2'b01, 8'h0, ~w}, 29, 2, 1'b1);
        rd_chk({1'b0, ~r[25:16]}, 1'b1, ~w);
        u_host.frame({1'b1, 2'b00, 2'b00, 8'h0}, 13, 0, 0, 0, rd);
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule
